/* File: shared/panel_pkg.sv */
// Shared constants and types for the front-panel switch and display logic.
package panel_pkg;

	// ------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned MS_PER_S      = 1000;
	localparam int unsigned DWELL_MS      = 1000;
	localparam int unsigned BLINK_MS      = 500;
	localparam int unsigned DWELL_CYC_DEF = DWELL_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned BLINK_CYC_DEF = BLINK_MS * (CLK_HZ / MS_PER_S);
	localparam int unsigned SETTLE_CYC    = 4;

	// ------------------------------------------------------------
	// Register map, byte addresses on the bus
	// ------------------------------------------------------------
	localparam logic [7:0] REG_MODE     = 8'h00;
	localparam logic [7:0] REG_DISP     = 8'h04;
	localparam logic [7:0] REG_DWELL    = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_CLR  = 8'h10;
	localparam logic [7:0] REG_IRQ_EN   = 8'h14;

	localparam int unsigned IRQ_W       = 3;
	localparam int unsigned IRQ_ALARM   = 0;
	localparam int unsigned IRQ_WDT     = 1;
	localparam int unsigned IRQ_DROP    = 2;
	localparam logic [IRQ_W-1:0] IRQ_EN_RST = 3'h0;

	// ------------------------------------------------------------
	// Modes, states and display symbols
	// ------------------------------------------------------------
	// Mode code is {first slide, second slide}, 1 meaning on.
	typedef enum logic [1:0] {
		MODE_FULL    = 2'h0,
		MODE_BASIC   = 2'h1,
		MODE_TEST    = 2'h2,
		MODE_FACTORY = 2'h3
	} mode_t;

	typedef enum logic [1:0] {
		DRV_READY_OFF = 2'h0,
		DRV_SERVO_OFF = 2'h1,
		DRV_SERVO_ON  = 2'h2
	} drive_t;

	typedef enum logic [1:0] {
		ST_STATUS  = 2'h0,
		ST_ALARM   = 2'h1,
		ST_NETINIT = 2'h3
	} seq_t;

	localparam int unsigned SYM_W = 5;
	localparam logic [4:0] SYM_B     = 5'h0b;
	localparam logic [4:0] SYM_D     = 5'h0d;
	localparam logic [4:0] SYM_F     = 5'h0f;
	localparam logic [4:0] SYM_N     = 5'h10;
	localparam logic [4:0] SYM_O     = 5'h11;
	localparam logic [4:0] SYM_CU    = 5'h12;
	localparam logic [4:0] SYM_DASH  = 5'h13;
	localparam logic [4:0] SYM_BLANK = 5'h14;
	localparam logic [4:0] SYM_ALL   = 5'h15;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] d2;
		logic [7:0] d1;
		logic [7:0] d0;
	} disp_t;

	typedef struct packed {
		logic       active;
		logic       init_comm;
		logic [7:0] number;
		logic [3:0] detail;
	} alarm_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] data;
	} cmd_t;

endpackage

/* File: logic/seg_encode.sv */
// Symbol code to seven-segment pattern, bit 0 is segment a.
`timescale 1ns/1ns
module seg_encode
	import panel_pkg::*;
(
	input  wire logic [SYM_W-1:0] sym_i,
	output logic      [6:0]       seg_o
);

	always_comb begin
		case (sym_i)
			5'h00:     seg_o = 7'h3f;
			5'h01:     seg_o = 7'h06;
			5'h02:     seg_o = 7'h5b;
			5'h03:     seg_o = 7'h4f;
			5'h04:     seg_o = 7'h66;
			5'h05:     seg_o = 7'h6d;
			5'h06:     seg_o = 7'h7d;
			5'h07:     seg_o = 7'h07;
			5'h08:     seg_o = 7'h7f;
			5'h09:     seg_o = 7'h6f;
			5'h0a:     seg_o = 7'h77;
			SYM_B:     seg_o = 7'h7c;
			5'h0c:     seg_o = 7'h58;
			SYM_D:     seg_o = 7'h5e;
			5'h0e:     seg_o = 7'h79;
			SYM_F:     seg_o = 7'h71;
			SYM_N:     seg_o = 7'h54;
			SYM_O:     seg_o = 7'h5c;
			SYM_CU:    seg_o = 7'h39;
			SYM_DASH:  seg_o = 7'h40;
			SYM_ALL:   seg_o = 7'h7f;
			default:   seg_o = 7'h00;
		endcase
	end

endmodule // seg_encode

/* File: logic/panel_display.sv */
// Front-panel switch capture, status display sequencer and register slave.
//
// Functional notes
// - Decode the two slide switches into full net, basic net, test, factory.
// - Read both rotary switches as one 8-bit station identifier, 0 to 255.
// - Identifier 1 to 255 becomes the last IP octet; zero is not used.
// - With no alarm, show the identifier as two hex digits at the right.
// - First digit shows b, C, d by drive state, or n during an alarm.
// - On alarm show status, then two-digit alarm number and detail digit.
// - Alarm during network start adds the network start status afterwards.
// - A processor watchdog trip lights every segment, showing 888.
// - A running test operation lights the decimal point after the letter.
// - In test mode all commands from the network master are ignored.
// - In the basic network variant the second network port stays unused.
// - Switch settings are captured once after power-up and then held.
// - Both slides on selects the factory mode and shows off.
// - In test mode the first decimal point blinks once initialised.
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ns
module panel_display
	import panel_pkg::*;
#(
	parameter int unsigned DWELL_CYCLES = DWELL_CYC_DEF,
	parameter int unsigned BLINK_CYCLES = BLINK_CYC_DEF
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        mode_slide_first_i,
	input  wire logic        mode_slide_second_i,
	input  wire logic [3:0]  id_rotary_high_i,
	input  wire logic [3:0]  id_rotary_low_i,
	input  wire logic [1:0]  drive_state_i,
	input  wire logic        init_done_i,
	input  wire alarm_t      alarm_i,
	input  wire logic [11:0] net_status_i,
	input  wire logic        watchdog_i,
	input  wire logic        test_op_i,
	input  wire cmd_t        cmd_i,
	output cmd_t             cmd_o,
	output disp_t            disp_o,
	output logic [7:0]       ip_octet4_o,
	output logic             ip_octet4_valid_o,
	output logic             second_network_port_en_o,
	output logic             test_mode_o,
	output logic             irq_o,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o
);

	// ------------------------------------------------------------
	// Switch capture
	// ------------------------------------------------------------
	logic [9:0]  sw_meta_q;
	logic [9:0]  sw_sync_q;
	logic [2:0]  settle_q;
	logic        latched_q;
	mode_t       mode_q;
	logic [7:0]  id_q;
	wire  [9:0]  sw_pins = {mode_slide_first_i, mode_slide_second_i,
	                        id_rotary_high_i, id_rotary_low_i};
	wire         settle_done = settle_q == 3'(SETTLE_CYC);

	always_ff @(posedge clk_i) begin
		sw_meta_q <= sw_pins;
		sw_sync_q <= sw_meta_q;
	end

	// Only a power cycle reaches rst_i, so a switch moved later is not seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			settle_q  <= 3'h0;
			latched_q <= 1'b0;
			mode_q    <= MODE_FULL;
			id_q      <= 8'h00;
		end else if (!latched_q) begin
			settle_q <= settle_done ? settle_q : settle_q + 3'h1;
			if (settle_done) begin
				latched_q <= 1'b1;
				mode_q    <= mode_t'(sw_sync_q[9:8]);
				id_q      <= sw_sync_q[7:0];
			end
		end
	end

	wire is_test    = latched_q && mode_q == MODE_TEST;
	wire is_factory = latched_q && mode_q == MODE_FACTORY;

	assign test_mode_o = is_test;
	assign ip_octet4_o = id_q;
	assign ip_octet4_valid_o = latched_q && id_q != 8'h00;
	// The second port serves only the full network variant.
	assign second_network_port_en_o = latched_q && mode_q == MODE_FULL;

	// ------------------------------------------------------------
	// Command gate
	// ------------------------------------------------------------
	cmd_t cmd_q;
	wire  cmd_block = !latched_q || is_test;
	wire  cmd_drop  = cmd_i.valid && cmd_block;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cmd_q <= '0;
		end else begin
			cmd_q.valid <= cmd_i.valid && !cmd_block;
			cmd_q.data  <= cmd_i.data;
		end
	end
	assign cmd_o = cmd_q;

	// ------------------------------------------------------------
	// Sequencer and blink timer
	// ------------------------------------------------------------
	seq_t        state_q;
	seq_t        state_d;
	logic [31:0] dwell_q;
	logic [31:0] dwell_cnt_q;
	logic [31:0] blink_cnt_q;
	logic        blink_q;
	wire         dwell_hit = (dwell_cnt_q + 32'h1) >= dwell_q;
	wire         blink_hit = blink_cnt_q == 32'(BLINK_CYCLES - 1);

	always_comb begin
		state_d = state_q;
		if (!alarm_i.active) begin
			state_d = ST_STATUS;
		end else if (dwell_hit) begin
			case (state_q)
				ST_STATUS:  state_d = ST_ALARM;
				ST_ALARM:   state_d = alarm_i.init_comm ? ST_NETINIT
				                                        : ST_STATUS;
				ST_NETINIT: state_d = ST_STATUS;
				default:    state_d = ST_STATUS;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !alarm_i.active || dwell_hit) begin
			dwell_cnt_q <= 32'h0;
		end else begin
			dwell_cnt_q <= dwell_cnt_q + 32'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q     <= ST_STATUS;
			blink_cnt_q <= 32'h0;
			blink_q     <= 1'b0;
		end else begin
			state_q     <= state_d;
			blink_cnt_q <= blink_hit ? 32'h0 : blink_cnt_q + 32'h1;
			blink_q     <= blink_hit ? !blink_q : blink_q;
		end
	end

	// ------------------------------------------------------------
	// Display content
	// ------------------------------------------------------------
	logic [SYM_W-1:0] sym_d [3];
	logic [SYM_W-1:0] sym_q [3];
	logic [2:0]       dp_d;
	logic [6:0]       seg_d [3];
	logic [SYM_W-1:0] letter;
	logic             letter_dp;

	always_comb begin
		case (drive_t'(drive_state_i))
			DRV_SERVO_OFF: letter = SYM_CU;
			DRV_SERVO_ON:  letter = SYM_D;
			default:       letter = SYM_B;
		endcase
		if (alarm_i.active) begin
			letter = SYM_N;
		end
	end

	// A running test operation holds the point steady; idle test mode blinks.
	assign letter_dp = test_op_i ? 1'b1
	                 : (is_test && blink_q);

	always_comb begin
		sym_d[2] = SYM_DASH;
		sym_d[1] = SYM_DASH;
		sym_d[0] = SYM_DASH;
		dp_d     = 3'h0;
		if (watchdog_i) begin
			sym_d[2] = SYM_ALL;
			sym_d[1] = SYM_ALL;
			sym_d[0] = SYM_ALL;
			dp_d     = 3'h7;
		end else if (is_factory) begin
			sym_d[2] = SYM_O;
			sym_d[1] = SYM_F;
			sym_d[0] = SYM_F;
		end else if (latched_q && init_done_i) begin
			case (state_q)
				ST_ALARM: begin
					sym_d[2] = {1'b0, alarm_i.number[7:4]};
					sym_d[1] = {1'b0, alarm_i.number[3:0]};
					sym_d[0] = {1'b0, alarm_i.detail};
					dp_d     = 3'h2;
				end
				ST_NETINIT: begin
					sym_d[2] = {1'b0, net_status_i[11:8]};
					sym_d[1] = {1'b0, net_status_i[7:4]};
					sym_d[0] = {1'b0, net_status_i[3:0]};
				end
				default: begin
					sym_d[2] = letter;
					sym_d[1] = {1'b0, id_q[7:4]};
					sym_d[0] = {1'b0, id_q[3:0]};
					dp_d     = {letter_dp, 2'h0};
				end
			endcase
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_digit
		seg_encode u_enc (
			.sym_i (sym_d[g]),
			.seg_o (seg_d[g])
		);
		always_ff @(posedge clk_i) begin
			sym_q[g] <= rst_i ? SYM_DASH : sym_d[g];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			disp_o <= '0;
		end else begin
			disp_o.d2 <= {dp_d[2], seg_d[2]};
			disp_o.d1 <= {dp_d[1], seg_d[1]};
			disp_o.d0 <= {dp_d[0], seg_d[0]};
		end
	end

	// ------------------------------------------------------------
	// Wishbone slave and interrupts
	// ------------------------------------------------------------
	logic             ack_q;
	logic [IRQ_W-1:0] irq_stat_q;
	logic [IRQ_W-1:0] irq_en_q;
	logic             alarm_prev_q;
	logic             wdt_prev_q;
	wire              req    = wb_cyc_i && wb_stb_i;
	wire              wr_hit = req && wb_we_i && ack_q;
	wire              wr_dwl = wr_hit && wb_adr_i == REG_DWELL;
	wire              wr_en  = wr_hit && wb_adr_i == REG_IRQ_EN && wb_sel_i[0];
	wire              wr_clr = wr_hit && wb_adr_i == REG_IRQ_CLR && wb_sel_i[0];
	wire [IRQ_W-1:0]  clr    = wr_clr ? wb_dat_i[IRQ_W-1:0] : '0;
	wire [IRQ_W-1:0]  ev;
	logic [31:0]      rd_mux;

	assign ev[IRQ_ALARM] = alarm_i.active && !alarm_prev_q;
	assign ev[IRQ_WDT]   = watchdog_i && !wdt_prev_q;
	assign ev[IRQ_DROP]  = cmd_drop;

	always_comb begin
		case (wb_adr_i)
			REG_MODE:     rd_mux = {16'h0, id_q, 5'h0, latched_q, mode_q};
			REG_DISP:     rd_mux = {disp_o, 3'h0, watchdog_i, 2'h0, state_q};
			REG_DWELL:    rd_mux = dwell_q;
			REG_IRQ_STAT: rd_mux = {29'h0, irq_stat_q};
			REG_IRQ_EN:   rd_mux = {29'h0, irq_en_q};
			default:      rd_mux = 32'h0;
		endcase
	end

	for (genvar b = 0; b < 4; b++) begin : g_lane
		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				dwell_q[8*b +: 8] <= 8'(DWELL_CYCLES >> (8 * b));
			end else if (wr_dwl && wb_sel_i[b]) begin
				dwell_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q        <= 1'b0;
			wb_dat_o     <= 32'h0;
			irq_stat_q   <= '0;
			irq_en_q     <= IRQ_EN_RST;
			alarm_prev_q <= 1'b0;
			wdt_prev_q   <= 1'b0;
		end else begin
			ack_q        <= req && !ack_q;
			wb_dat_o     <= (req && !ack_q) ? rd_mux : wb_dat_o;
			// A new event in the clearing cycle stays set.
			irq_stat_q   <= (irq_stat_q & ~clr) | ev;
			irq_en_q     <= wr_en ? wb_dat_i[IRQ_W-1:0] : irq_en_q;
			alarm_prev_q <= alarm_i.active;
			wdt_prev_q   <= watchdog_i;
		end
	end

	assign wb_ack_o = ack_q;
	assign irq_o    = |(irq_stat_q & irq_en_q);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_alarm_step;
		state_q == ST_ALARM && dwell_hit && alarm_i.active;
	endsequence

	a_wdt_pattern: assert property (watchdog_i |=>
		disp_o == 24'hffffff)
		else $error("watchdog did not light all segments");
	a_cmd_block: assert property (is_test && cmd_i.valid |=>
		!cmd_o.valid)
		else $error("command passed in test mode");
	a_id_hold: assert property (latched_q && $past(latched_q) |->
		$stable(id_q) && $stable(mode_q))
		else $error("switch setting changed after capture");
	a_ip_zero: assert property (latched_q && id_q == 8'h00 |->
		!ip_octet4_valid_o)
		else $error("zero identifier offered as octet");
	a_port_unused: assert property (latched_q && mode_q == MODE_BASIC |->
		!second_network_port_en_o)
		else $error("second port enabled in basic variant");
	a_alarm_step: assert property (state_q == ST_STATUS && dwell_hit &&
		alarm_i.active |=> state_q == ST_ALARM)
		else $error("alarm number step skipped");
	a_net_step: assert property (s_alarm_step ##0 alarm_i.init_comm |=>
		state_q == ST_NETINIT ##1 (!alarm_i.active || dwell_q <= 32'h1 ||
		dwell_cnt_q == 32'h1))
		else $error("network status step missing");
	a_factory_off: assert property (is_factory && !watchdog_i |=>
		sym_q[2] == SYM_O && sym_q[1] == SYM_F && sym_q[0] == SYM_F)
		else $error("factory mode not showing off");
	a_id_digits: assert property (latched_q && init_done_i && !watchdog_i &&
		!is_factory && !alarm_i.active && state_q == ST_STATUS |=>
		sym_q[1] == {1'b0, $past(id_q[7:4])} && sym_q[0] == {1'b0, $past(id_q[3:0])})
		else $error("identifier digits wrong");
	a_test_point: assert property (test_op_i && latched_q && init_done_i &&
		!watchdog_i && !is_factory && state_q == ST_STATUS |=> disp_o.d2[7])
		else $error("test point not lit");

endmodule // panel_display

/* File: test/panel_model.sv */
// Operator panel model: slide and rotary switches as set by the bench.
`timescale 1ns/1ns
module panel_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] mode_set_i,
	input  wire logic [7:0] id_set_i,
	output logic            mode_slide_first_o,
	output logic            mode_slide_second_o,
	output logic [3:0]      id_rotary_high_o,
	output logic [3:0]      id_rotary_low_o
);
	// Contacts move a cycle after the bench asks, like a hand on a switch.
	always_ff @(posedge clk_i) begin
		{mode_slide_first_o, mode_slide_second_o} <= mode_set_i;
		{id_rotary_high_o, id_rotary_low_o}       <= id_set_i;
	end
endmodule // panel_model

/* File: test/switch_mode_and_status_display_test.sv */
// Self-checking bench for the panel switch capture and status display.
`timescale 1ns/1ns
module switch_mode_and_status_display_test;
	import panel_pkg::*;
	localparam int DW = 8;
	localparam logic [6:0] GLY [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
		7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h58,
		7'h5e, 7'h79, 7'h71};
	logic        clk_i = 0, rst_i = 1, init_done = 0, watchdog = 0;
	logic        test_op = 0, wb_cyc = 0, wb_stb = 0, wb_we = 0, wb_ack;
	logic        sl1, sl2, ip4_v, port2, tmode, irq;
	logic [1:0]  mode_set = '0, drive_st = '0;
	logic [3:0]  rh, rl;
	logic [7:0]  id_set = '0, wb_adr = '0, ip4;
	logic [11:0] net_st = '0;
	logic [31:0] wb_dat = '0, wb_q, seed = 32'h4e1cd5c2;
	alarm_t      alarm = '0;
	cmd_t        cmd_in = '0, cmd_out;
	disp_t       disp;
	int          n_errors = 0, checks = 0;

	always #25 clk_i = ~clk_i;

	panel_model i_model (.clk_i(clk_i), .mode_set_i(mode_set),
		.id_set_i(id_set), .mode_slide_first_o(sl1),
		.mode_slide_second_o(sl2), .id_rotary_high_o(rh),
		.id_rotary_low_o(rl));

	panel_display #(.DWELL_CYCLES(DW), .BLINK_CYCLES(4)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .mode_slide_first_i(sl1),
		.mode_slide_second_i(sl2), .id_rotary_high_i(rh),
		.id_rotary_low_i(rl), .drive_state_i(drive_st),
		.init_done_i(init_done), .alarm_i(alarm), .net_status_i(net_st),
		.watchdog_i(watchdog), .test_op_i(test_op), .cmd_i(cmd_in),
		.cmd_o(cmd_out), .disp_o(disp), .ip_octet4_o(ip4),
		.ip_octet4_valid_o(ip4_v), .second_network_port_en_o(port2),
		.test_mode_o(tmode), .irq_o(irq), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(4'hf), .wb_dat_i(wb_dat), .wb_dat_o(wb_q),
		.wb_ack_o(wb_ack));

	// ------------------------------------------------------------
	// Expectation helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic disp_t st_item(input logic [1:0] ds,
		input logic al, input logic dp, input logic [7:0] id);
		logic [6:0] l;
		l = al ? 7'h54 : (ds == 2'h1) ? 7'h39 : (ds == 2'h2) ? 7'h5e : 7'h7c;
		return {dp, l, 1'b0, GLY[id[7:4]], 1'b0, GLY[id[3:0]]};
	endfunction

	task automatic chk(input logic [31:0] seen, exp, input string what);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("TB: checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus and sequence tasks
	// ------------------------------------------------------------
	task automatic wb(input logic we, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int t;
		t = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat <= d;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack !== 1'b1 && t < 20);
		// A slave that never answers counts as a mismatch.
		if (wb_ack !== 1'b1) n_errors++;
		q = wb_q;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(negedge clk_i);
	endtask

	task automatic power_up(input logic [1:0] m, input logic [7:0] id);
		@(posedge clk_i);
		rst_i <= 1'b1;
		mode_set <= m;
		id_set <= id;
		init_done <= 1'b0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		init_done <= 1'b1;
		repeat (2) @(negedge clk_i);
	endtask

	// Waits for a display item and reports how many cycles it took.
	task automatic await(input disp_t e, output int n);
		n = 0;
		while (disp !== e && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		chk(disp, e, "sequence");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		#3_000_000;
		n_errors++;
		give_verdict();
	end

	initial begin
		logic [31:0] q;
		logic [11:0] b;
		logic [1:0]  m;
		logic [7:0]  id;
		logic [15:0] cd;
		int          n;
		for (int i = 0; i < 8; i++) begin
			m = 2'(i);
			id = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'(rnd());
			power_up(m, id);
			@(posedge clk_i);
			drive_st <= 2'(rnd());
			test_op <= (m == 2'h2);
			repeat (2) @(negedge clk_i);
			chk(tmode, m == 2'h2, "test_mode");
			chk(port2, m == 2'h0, "port2_en");
			chk(ip4_v, id != 8'h00, "ip_valid");
			chk(ip4, id, "ip_octet");
			chk(disp, (m == 2'h3) ? 24'h5c7171 : st_item(drive_st, 1'b0,
				m == 2'h2, id), "display");
			wb(1'b0, REG_MODE, '0, q);
			chk({q[15:8], q[2:0]}, {id, 1'b1, m}, "mode_reg");
			@(posedge clk_i);
			cd = 16'(rnd());
			cmd_in <= {1'b1, cd};
			@(posedge clk_i);
			cmd_in <= '0;
			@(negedge clk_i);
			chk(cmd_out.valid, m != 2'h2, "cmd_pass");
			if (m != 2'h2) chk(cmd_out.data, cd, "cmd_data");
			wb(1'b0, REG_IRQ_STAT, '0, q);
			chk(q[2:0], {m == 2'h2, 2'h0}, "irq_drop");
			@(posedge clk_i);
			mode_set <= ~m;
			id_set <= ~id;
			test_op <= 1'b0;
			repeat (4) @(negedge clk_i);
			for (int k = 0; k < 12; k++) begin
				@(negedge clk_i);
				b = {b[10:0], disp.d2[7]};
			end
			chk({tmode, ip4}, {m == 2'h2, id}, "held");
			if (m == 2'h2)
				chk((|b) && !(&b), 1'b1, "blink");
		end
		power_up(2'h0, 8'h3c);
		wb(1'b0, REG_DWELL, '0, q);
		chk(q, DW, "dwell_reset");
		wb(1'b0, 8'h40, '0, q);
		chk(q, '0, "unmapped");
		wb(1'b1, REG_IRQ_EN, 32'h1, q);
		@(posedge clk_i);
		alarm <= {2'h3, 8'(rnd()), 4'(rnd())};
		net_st <= 12'(rnd());
		@(negedge clk_i);
		await(st_item(drive_st, 1'b1, 1'b0, 8'h3c), n);
		for (int r = 0; r < 2; r++) begin
			await({1'b0, GLY[alarm.number[7:4]], 1'b1, GLY[alarm.number[3:0]],
				1'b0, GLY[alarm.detail]}, n);
			chk(n, DW, "dwell");
			await({1'b0, GLY[net_st[11:8]], 1'b0, GLY[net_st[7:4]], 1'b0,
				GLY[net_st[3:0]]}, n);
			chk(n, DW, "dwell");
			await(st_item(drive_st, 1'b1, 1'b0, 8'h3c), n);
		end
		chk(irq, 1'b1, "irq_raise");
		wb(1'b1, REG_IRQ_EN, 32'h0, q);
		chk(irq, 1'b0, "irq_mask");
		wb(1'b1, REG_IRQ_EN, 32'h1, q);
		wb(1'b1, REG_IRQ_CLR, 32'h1, q);
		wb(1'b0, REG_IRQ_STAT, '0, q);
		chk({irq, q[0]}, 2'h0, "irq_clear");
		@(posedge clk_i);
		watchdog <= 1'b1;
		repeat (2) @(negedge clk_i);
		chk(disp, 24'hffffff, "watchdog");
		wb(1'b0, REG_DISP, '0, q);
		chk(q[31:4], {24'hffffff, 4'h1}, "disp_reg");
		wb(1'b0, REG_IRQ_STAT, '0, q);
		chk(q[2:0], 3'h2, "irq_wdt");
		give_verdict();
	end
endmodule // switch_mode_and_status_display_test
